// ==== hdl/apcr_top.sv ====
// Analog power control register bank with APB slave
`default_nettype none
module apcr_top (
   input wire logic MCLK_IN,
   input wire logic RST_N_IN,
   input wire logic INIT_RST_IN,
   input wire logic PSEL_IN,
   input wire logic PENABLE_IN,
   input wire logic PWRITE_IN,
   input wire logic [apcr_pkg::ADDR_W-1:0] PADDR_IN,
   input wire logic [31:0] PWDATA_IN,
   input wire logic [3:0] PSTRB_IN,
   output logic [31:0] PRDATA_OUT,
   output logic PREADY_OUT,
   output logic PSLVERR_OUT,
   input wire logic FAST_OSC_ON_IN,
   output logic BANDGAP_ENABLE_OUT,
   output logic REGULATOR_ENABLE_OUT,
   output logic [2:0] REGULATOR_LEVEL_SELECT_OUT,
   output logic [1:0] REGULATOR_OFF_DRIVE_SELECT_OUT,
   output logic REF_OUT_BUFFER_ENABLE_OUT,
   output logic REF_DIVIDER_ENABLE_OUT,
   output logic [2:0] ANALOG_GROUND_LEVEL_SELECT_OUT,
   output logic CHARGE_PUMP_ENABLE_OUT,
   output logic PUMP_OUTPUT_SELECT_OUT,
   output logic REGULATOR_PULLDOWN_ENABLE_OUT,
   output logic TEMP_SENSOR_ENABLE_OUT,
   output logic REF_BUFFER_SOURCE_SELECT_OUT
);
   logic rst_n;
   logic setup;
   logic hit;
   logic [apcr_pkg::NUM_REGS-1:0] wr;
   logic [7:0] rdata;

   logic [7:0] power_control;
   logic [7:0] power_reference_control;
   logic [7:0] pump_sensor_control;
   logic [7:0] measure_network_control;
   logic [7:0] next_power_control;
   logic [7:0] next_power_reference_control;
   logic [7:0] next_pump_sensor_control;
   logic [7:0] next_measure_network_control;

   wire [7:0] wbyte = PWDATA_IN[7:0];
   wire [7:0] init_power_control =
      (power_control & ~apcr_pkg::INIT_CLR_POWER_CONTROL) | apcr_pkg::INIT_SET_POWER_CONTROL;

   apcr_reset_sync u_rst (
      .clk_in(MCLK_IN),
      .rst_n_in(RST_N_IN),
      .rst_n_out(rst_n)
   );

   apcr_apb_decode u_dec (
      .psel_in(PSEL_IN),
      .penable_in(PENABLE_IN),
      .pwrite_in(PWRITE_IN),
      .pready_in(PREADY_OUT),
      .paddr_in(PADDR_IN),
      .pstrb_in(PSTRB_IN),
      .rd_power_in(power_control & apcr_pkg::RDMASK_POWER_CONTROL),
      .rd_reference_in(power_reference_control),
      .rd_pump_in(pump_sensor_control),
      .rd_network_in(measure_network_control),
      .setup_out(setup),
      .hit_out(hit),
      .wr_out(wr),
      .rdata_out(rdata)
   );

   // Second reset kind outranks a write in the same cycle
   assign next_power_control = INIT_RST_IN ? init_power_control :
      wr[0] ? (wbyte & apcr_pkg::MASK_POWER_CONTROL) : power_control;
   assign next_power_reference_control = (wr[1] && !INIT_RST_IN) ?
      (wbyte & apcr_pkg::MASK_POWER_REFERENCE_CONTROL) : power_reference_control;
   assign next_pump_sensor_control = (wr[2] && !INIT_RST_IN) ?
      (wbyte & apcr_pkg::MASK_PUMP_SENSOR_CONTROL) : pump_sensor_control;
   assign next_measure_network_control = (wr[3] && !INIT_RST_IN) ?
      (wbyte & apcr_pkg::MASK_MEASURE_NETWORK_CONTROL) : measure_network_control;

   // Decoded analog controls, taken from the next register values so they land with the write
   wire next_reg_en = next_power_control[apcr_pkg::REGULATOR_ENABLE_BIT];
   wire [2:0] next_level = next_power_control[apcr_pkg::REGULATOR_LEVEL_LSB +: 3];
   wire [1:0] next_off_field = next_power_control[apcr_pkg::REGULATOR_OFF_DRIVE_LSB +: 2];
   // Off drive only while regulator is off; reserved code is treated as high impedance
   wire [1:0] next_off_drive = (next_reg_en || next_off_field == apcr_pkg::OFF_DRIVE_RESERVED) ?
      apcr_pkg::OFF_DRIVE_HIGHZ : next_off_field;
   // Oscillator keeps the band-gap alive regardless of the bit
   wire next_bandgap = next_power_control[apcr_pkg::BANDGAP_ENABLE_BIT] | FAST_OSC_ON_IN;
   wire [2:0] next_ground_field =
      next_power_reference_control[apcr_pkg::ANALOG_GROUND_LSB +: 3];
   // Undefined ground codes float the pin rather than pick a level
   wire [2:0] next_ground = (next_ground_field > apcr_pkg::ANALOG_GROUND_LAST_CODE) ?
      apcr_pkg::ANALOG_GROUND_FLOAT : next_ground_field;
   wire next_pump_en = next_pump_sensor_control[apcr_pkg::CHARGE_PUMP_ENABLE_BIT];
   wire next_pump_double =
      next_pump_sensor_control[apcr_pkg::PUMP_OUTPUT_SELECT_BIT] & next_pump_en;

   // Register file
   always_ff @(posedge MCLK_IN or negedge rst_n) begin
      if (!rst_n) begin
         power_control <= apcr_pkg::RST_POWER_CONTROL;
         power_reference_control <= apcr_pkg::RST_POWER_REFERENCE_CONTROL;
         pump_sensor_control <= apcr_pkg::RST_PUMP_SENSOR_CONTROL;
         measure_network_control <= apcr_pkg::RST_MEASURE_NETWORK_CONTROL;
      end else begin
         power_control <= next_power_control;
         power_reference_control <= next_power_reference_control;
         pump_sensor_control <= next_pump_sensor_control;
         measure_network_control <= next_measure_network_control;
      end
   end

   // APB answer: ready and data registered in the setup cycle, one access cycle
   always_ff @(posedge MCLK_IN or negedge rst_n) begin
      if (!rst_n) begin
         PREADY_OUT <= 1'b0;
         PSLVERR_OUT <= 1'b0;
         PRDATA_OUT <= 32'h0000_0000;
      end else begin
         PREADY_OUT <= setup;
         PSLVERR_OUT <= setup & ~hit;
         PRDATA_OUT <= (setup && !PWRITE_IN) ? {24'h00_0000, rdata} : 32'h0000_0000;
      end
   end

   // Analog control outputs
   always_ff @(posedge MCLK_IN or negedge rst_n) begin
      if (!rst_n) begin
         BANDGAP_ENABLE_OUT <= 1'b1;
         REGULATOR_ENABLE_OUT <= 1'b0;
         REGULATOR_LEVEL_SELECT_OUT <= 3'h0;
         REGULATOR_OFF_DRIVE_SELECT_OUT <= apcr_pkg::OFF_DRIVE_HIGHZ;
         REF_OUT_BUFFER_ENABLE_OUT <= 1'b0;
         REF_DIVIDER_ENABLE_OUT <= 1'b0;
         ANALOG_GROUND_LEVEL_SELECT_OUT <= apcr_pkg::ANALOG_GROUND_FLOAT;
         CHARGE_PUMP_ENABLE_OUT <= 1'b0;
         PUMP_OUTPUT_SELECT_OUT <= 1'b0;
         REGULATOR_PULLDOWN_ENABLE_OUT <= 1'b0;
         TEMP_SENSOR_ENABLE_OUT <= 1'b0;
         REF_BUFFER_SOURCE_SELECT_OUT <= 1'b0;
      end else begin
         BANDGAP_ENABLE_OUT <= next_bandgap;
         REGULATOR_ENABLE_OUT <= next_reg_en;
         REGULATOR_LEVEL_SELECT_OUT <= next_level;
         REGULATOR_OFF_DRIVE_SELECT_OUT <= next_off_drive;
         REF_OUT_BUFFER_ENABLE_OUT <=
            next_power_reference_control[apcr_pkg::REF_OUT_BUFFER_ENABLE_BIT];
         REF_DIVIDER_ENABLE_OUT <=
            next_power_reference_control[apcr_pkg::REF_DIVIDER_ENABLE_BIT];
         ANALOG_GROUND_LEVEL_SELECT_OUT <= next_ground;
         CHARGE_PUMP_ENABLE_OUT <= next_pump_en;
         PUMP_OUTPUT_SELECT_OUT <= next_pump_double;
         REGULATOR_PULLDOWN_ENABLE_OUT <=
            next_pump_sensor_control[apcr_pkg::REGULATOR_PULLDOWN_BIT];
         TEMP_SENSOR_ENABLE_OUT <=
            next_pump_sensor_control[apcr_pkg::TEMP_SENSOR_ENABLE_BIT];
         REF_BUFFER_SOURCE_SELECT_OUT <=
            next_measure_network_control[apcr_pkg::REF_BUFFER_SOURCE_BIT];
      end
   end

   // Checks
   default clocking cb @(posedge MCLK_IN);
   endclocking
   default disable iff (!rst_n);

   wire wr_pwr = wr[0] & ~INIT_RST_IN;
   wire wr_ref = wr[1] & ~INIT_RST_IN;
   wire wr_pmp = wr[2] & ~INIT_RST_IN;
   wire wr_net = wr[3] & ~INIT_RST_IN;

   AST_LEVEL_WRITE: assert property (wr_pwr |=>
      REGULATOR_LEVEL_SELECT_OUT == $past(PWDATA_IN[6:4]))
      else $error("regulator level does not follow write");

   AST_OFF_DRIVE_GATED: assert property (REGULATOR_ENABLE_OUT |->
      REGULATOR_OFF_DRIVE_SELECT_OUT == apcr_pkg::OFF_DRIVE_HIGHZ)
      else $error("off drive active while regulator on");

   AST_OFF_DRIVE_WRITE: assert property ((wr_pwr && !PWDATA_IN[1] &&
      PWDATA_IN[3:2] != apcr_pkg::OFF_DRIVE_RESERVED) |=>
      REGULATOR_OFF_DRIVE_SELECT_OUT == $past(PWDATA_IN[3:2]))
      else $error("off drive does not follow write");

   AST_ENABLE_WRITE: assert property (wr_pwr |=>
      REGULATOR_ENABLE_OUT == $past(PWDATA_IN[1]))
      else $error("regulator enable does not follow write");

   AST_BANDGAP_OSC: assert property (FAST_OSC_ON_IN |=> BANDGAP_ENABLE_OUT)
      else $error("band-gap off while fast oscillator runs");

   AST_BANDGAP_INIT: assert property (INIT_RST_IN |=>
      power_control[7] && power_control[3:2] == 2'h0 &&
      power_control[6:4] == $past(power_control[6:4]))
      else $error("second reset mishandles power control");

   AST_REFBUF_WRITE: assert property (wr_ref |=>
      REF_OUT_BUFFER_ENABLE_OUT == $past(PWDATA_IN[7]))
      else $error("reference buffer enable does not follow write");

   AST_DIVIDER_WRITE: assert property (wr_ref |=>
      REF_DIVIDER_ENABLE_OUT == $past(PWDATA_IN[3]))
      else $error("divider enable does not follow write");

   AST_GROUND_LEGAL: assert property ((wr_ref && PWDATA_IN[2:0] <= 3'h4) |=>
      ANALOG_GROUND_LEVEL_SELECT_OUT == $past(PWDATA_IN[2:0]))
      else $error("ground level does not follow legal write");

   AST_PUMP_DOUBLE: assert property (PUMP_OUTPUT_SELECT_OUT |-> CHARGE_PUMP_ENABLE_OUT)
      else $error("pump doubling without pump enabled");

   AST_TEMP_WRITE: assert property (wr_pmp |=>
      TEMP_SENSOR_ENABLE_OUT == $past(PWDATA_IN[1]))
      else $error("temperature sensor enable does not follow write");

   AST_SOURCE_WRITE: assert property (wr_net |=>
      REF_BUFFER_SOURCE_SELECT_OUT == $past(PWDATA_IN[6]))
      else $error("buffer source does not follow write");

   AST_HOLD: assert property ((!wr[1] && !INIT_RST_IN)[*2] |=>
      $stable(REF_DIVIDER_ENABLE_OUT) && $stable(ANALOG_GROUND_LEVEL_SELECT_OUT))
      else $error("reference controls changed without write");

   AST_APB_ONE_WAIT: assert property ((PSEL_IN && !PENABLE_IN) |=> PREADY_OUT)
      else $error("slave did not answer after setup");

   // Bus answer checks
   AST_READY_ONLY_AFTER_SETUP: assert property (!(PSEL_IN && !PENABLE_IN) |=> !PREADY_OUT)
      else $error("ready raised without a setup cycle");

   AST_SLVERR_UNMAPPED: assert property ((PSEL_IN && !PENABLE_IN) |=>
      PSLVERR_OUT == !$past(hit))
      else $error("slave error does not match address decode");

   AST_SLVERR_WITH_READY: assert property (PSLVERR_OUT |-> PREADY_OUT)
      else $error("slave error without ready");

   AST_RDATA_IDLE: assert property (!(PSEL_IN && !PENABLE_IN && !PWRITE_IN) |=>
      PRDATA_OUT == 32'h0000_0000)
      else $error("read data not zero outside a read access");

   AST_READ_POWER: assert property ((PSEL_IN && !PENABLE_IN && !PWRITE_IN &&
      PADDR_IN == apcr_pkg::REG_ADDR[0]) |=>
      PRDATA_OUT == {24'h00_0000, $past(power_control) & apcr_pkg::RDMASK_POWER_CONTROL})
      else $error("power control read data wrong");

   AST_READ_REFERENCE: assert property ((PSEL_IN && !PENABLE_IN && !PWRITE_IN &&
      PADDR_IN == apcr_pkg::REG_ADDR[1]) |=>
      PRDATA_OUT == {24'h00_0000, $past(power_reference_control)})
      else $error("reference control read data wrong");

   AST_READ_PUMP: assert property ((PSEL_IN && !PENABLE_IN && !PWRITE_IN &&
      PADDR_IN == apcr_pkg::REG_ADDR[2]) |=>
      PRDATA_OUT == {24'h00_0000, $past(pump_sensor_control)})
      else $error("pump and sensor read data wrong");

   // Register and output checks
   AST_STROBE_OFF: assert property ((PSEL_IN && PENABLE_IN && PREADY_OUT &&
      PWRITE_IN && !PSTRB_IN[0] && !INIT_RST_IN) |=> $stable(power_control) &&
      $stable(power_reference_control) && $stable(pump_sensor_control) &&
      $stable(measure_network_control))
      else $error("write with byte strobe off changed a register");

   AST_UNMAPPED_WRITE: assert property ((PSEL_IN && PENABLE_IN && PREADY_OUT &&
      PWRITE_IN && !hit && !INIT_RST_IN) |=> $stable(power_control) &&
      $stable(power_reference_control) && $stable(pump_sensor_control) &&
      $stable(measure_network_control))
      else $error("write to an unmapped address changed a register");

   AST_PUMP_WRITE: assert property (wr_pmp |=>
      CHARGE_PUMP_ENABLE_OUT == $past(PWDATA_IN[7]))
      else $error("charge pump enable does not follow write");

   AST_PUMP_SELECT_WRITE: assert property (wr_pmp |=>
      PUMP_OUTPUT_SELECT_OUT == ($past(PWDATA_IN[6]) && $past(PWDATA_IN[7])))
      else $error("pump output select does not follow write");

   AST_PULLDOWN_WRITE: assert property (wr_pmp |=>
      REGULATOR_PULLDOWN_ENABLE_OUT == $past(PWDATA_IN[2]))
      else $error("regulator pull-down does not follow write");

   AST_GROUND_ILLEGAL: assert property ((wr_ref && PWDATA_IN[2:0] > 3'h4) |=>
      ANALOG_GROUND_LEVEL_SELECT_OUT == apcr_pkg::ANALOG_GROUND_FLOAT)
      else $error("undefined ground code does not float the pin");

   AST_OFF_DRIVE_RESERVED: assert property ((wr_pwr && PWDATA_IN[3:2] == 2'h3) |=>
      REGULATOR_OFF_DRIVE_SELECT_OUT == apcr_pkg::OFF_DRIVE_HIGHZ)
      else $error("reserved off drive code drives the pin");

   AST_BANDGAP_BIT: assert property (wr_pwr |=>
      BANDGAP_ENABLE_OUT == ($past(PWDATA_IN[7]) || $past(FAST_OSC_ON_IN)))
      else $error("band-gap enable does not follow write");

   AST_INIT_OUTPUTS: assert property (INIT_RST_IN |=>
      BANDGAP_ENABLE_OUT && REGULATOR_OFF_DRIVE_SELECT_OUT == apcr_pkg::OFF_DRIVE_HIGHZ)
      else $error("second reset does not reach the outputs");

   AST_INIT_KEEPS: assert property (INIT_RST_IN |=>
      $stable(power_reference_control) && $stable(pump_sensor_control) &&
      $stable(measure_network_control))
      else $error("second reset changed a kept register");

   COV_REG_ON: cover property (wr_pwr && PWDATA_IN[1]);
   COV_OSC_OVERRIDE: cover property (FAST_OSC_ON_IN && !power_control[7]);
   COV_UNMAPPED: cover property (PSLVERR_OUT && PENABLE_IN);
   COV_INIT_RESET: cover property (INIT_RST_IN && power_control[3:2] != 2'h0);
   COV_PUMP_DOUBLE: cover property (PUMP_OUTPUT_SELECT_OUT);
endmodule
`default_nettype wire

// ==== hdl/apcr_pkg.sv ====
// Constants shared by the analog power control register bank
// How it works
// - A three-bit level field picks one of eight regulator voltages and reaches the output whether or not the regulator is enabled.
// - With the regulator off, a two-bit field sets the supply pin drive; code 11 is reserved.
// - Bit 1 of the power control register turns the analog supply regulator on or off.
// - The band-gap bit resets to one and the band-gap stays on while the fast oscillator runs.
// - Bit 7 of the reference control register enables the reference-output buffer.
// - Bit 3 of the reference control register enables the reference-divider generator.
// - A three-bit field selects the analog ground level, with code 000 floating the pin.
// - The pump select bit doubles the pump output only while the charge pump is enabled.
// - Bit 1 of the pump and sensor register enables the temperature sensor.
// - Bit 6 of the network register picks the reference buffer source, band-gap by default.
`default_nettype none
package apcr_pkg;
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned NUM_REGS = 4;

   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_POWER_CONTROL = 8'h32;
   localparam logic [7:0] IDX_POWER_REFERENCE_CONTROL = 8'h33;
   localparam logic [7:0] IDX_PUMP_SENSOR_CONTROL = 8'h34;
   localparam logic [7:0] IDX_MEASURE_NETWORK_CONTROL = 8'h42;
   localparam logic [ADDR_W-1:0] REG_ADDR [NUM_REGS] = '{
      {2'h0, IDX_POWER_CONTROL, 2'h0},
      {2'h0, IDX_POWER_REFERENCE_CONTROL, 2'h0},
      {2'h0, IDX_PUMP_SENSOR_CONTROL, 2'h0},
      {2'h0, IDX_MEASURE_NETWORK_CONTROL, 2'h0}
   };

   // Full reset values
   localparam logic [7:0] RST_POWER_CONTROL = 8'h80;
   localparam logic [7:0] RST_POWER_REFERENCE_CONTROL = 8'h00;
   localparam logic [7:0] RST_PUMP_SENSOR_CONTROL = 8'h00;
   localparam logic [7:0] RST_MEASURE_NETWORK_CONTROL = 8'h00;

   // Implemented bits per register
   localparam logic [7:0] MASK_POWER_CONTROL = 8'hfe;
   localparam logic [7:0] MASK_POWER_REFERENCE_CONTROL = 8'h8f;
   localparam logic [7:0] MASK_PUMP_SENSOR_CONTROL = 8'hc6;
   localparam logic [7:0] MASK_MEASURE_NETWORK_CONTROL = 8'h40;
   // Off-drive field is write-only, reads zero
   localparam logic [7:0] RDMASK_POWER_CONTROL = 8'hf2;

   // Second reset: bit 7 set, off-drive cleared, rest kept
   localparam logic [7:0] INIT_SET_POWER_CONTROL = 8'h80;
   localparam logic [7:0] INIT_CLR_POWER_CONTROL = 8'h0c;

   // Field positions
   localparam int unsigned BANDGAP_ENABLE_BIT = 7;
   localparam int unsigned REGULATOR_LEVEL_LSB = 4;
   localparam int unsigned REGULATOR_OFF_DRIVE_LSB = 2;
   localparam int unsigned REGULATOR_ENABLE_BIT = 1;
   localparam int unsigned REF_OUT_BUFFER_ENABLE_BIT = 7;
   localparam int unsigned REF_DIVIDER_ENABLE_BIT = 3;
   localparam int unsigned ANALOG_GROUND_LSB = 0;
   localparam int unsigned CHARGE_PUMP_ENABLE_BIT = 7;
   localparam int unsigned PUMP_OUTPUT_SELECT_BIT = 6;
   localparam int unsigned REGULATOR_PULLDOWN_BIT = 2;
   localparam int unsigned TEMP_SENSOR_ENABLE_BIT = 1;
   localparam int unsigned REF_BUFFER_SOURCE_BIT = 6;

   // Off-state drive codes
   localparam logic [1:0] OFF_DRIVE_HIGHZ = 2'h0;
   localparam logic [1:0] OFF_DRIVE_SUPPLY = 2'h1;
   localparam logic [1:0] OFF_DRIVE_PULLUP = 2'h2;
   localparam logic [1:0] OFF_DRIVE_RESERVED = 2'h3;

   // Analog ground codes
   localparam logic [2:0] ANALOG_GROUND_FLOAT = 3'h0;
   localparam logic [2:0] ANALOG_GROUND_LAST_CODE = 3'h4;
endpackage
`default_nettype wire

// ==== hdl/apcr_reset_sync.sv ====
// Reset release synchroniser
`default_nettype none
module apcr_reset_sync (
   input wire logic clk_in,
   input wire logic rst_n_in,
   output logic rst_n_out
);
   logic stage1;

   // Assert at once, release two edges later
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         stage1 <= 1'b0;
         rst_n_out <= 1'b0;
      end else begin
         stage1 <= 1'b1;
         rst_n_out <= stage1;
      end
   end
endmodule
`default_nettype wire

// ==== hdl/apcr_apb_decode.sv ====
// APB address decode, write strobes and read mux
`default_nettype none
module apcr_apb_decode (
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic pready_in,
   input wire logic [apcr_pkg::ADDR_W-1:0] paddr_in,
   input wire logic [3:0] pstrb_in,
   input wire logic [7:0] rd_power_in,
   input wire logic [7:0] rd_reference_in,
   input wire logic [7:0] rd_pump_in,
   input wire logic [7:0] rd_network_in,
   output logic setup_out,
   output logic hit_out,
   output logic [apcr_pkg::NUM_REGS-1:0] wr_out,
   output logic [7:0] rdata_out
);
   logic [apcr_pkg::NUM_REGS-1:0] hit_vec;
   logic [7:0] rd_arr [apcr_pkg::NUM_REGS];
   wire write_done = psel_in & penable_in & pready_in & pwrite_in & pstrb_in[0];

   assign rd_arr[0] = rd_power_in;
   assign rd_arr[1] = rd_reference_in;
   assign rd_arr[2] = rd_pump_in;
   assign rd_arr[3] = rd_network_in;
   assign setup_out = psel_in & ~penable_in;
   assign hit_out = |hit_vec;

   genvar i;
   generate
      for (i = 0; i < apcr_pkg::NUM_REGS; i++) begin : g_reg
         assign hit_vec[i] = (paddr_in == apcr_pkg::REG_ADDR[i]);
         // Upper byte lanes have no storage
         assign wr_out[i] = hit_vec[i] & write_done;
      end
   endgenerate

   always_comb begin
      rdata_out = 8'h00;
      for (int k = 0; k < apcr_pkg::NUM_REGS; k++) begin
         if (hit_vec[k]) begin
            rdata_out = rdata_out | rd_arr[k];
         end
      end
   end
endmodule
`default_nettype wire

// ==== verif/apcr_top_test.sv ====
// Self-checking testbench for the analog power control register bank
`default_nettype none
module apcr_top_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [11:0] A_PC = 12'h0c8;
   localparam logic [11:0] A_PR = 12'h0cc;
   localparam logic [11:0] A_PS = 12'h0d0;
   localparam logic [11:0] A_NW = 12'h108;
   localparam logic [11:0] A_BAD = 12'h0d4;
   // Regulator settle time: 500 us in 40 ns cycles
   localparam int SETTLE_CYCLES = 12500;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic init_rst = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [3:0] pstrb = 4'hf;
   logic osc = 1'b0;
   logic [31:0] prdata;
   logic pready, pslverr, bg, ren, buf_en, div_en, pump, psel_out, pd, temp, src;
   logic [2:0] lvl, gnd;
   logic [1:0] drv;
   int n_fail = 0;
   int checks = 0;

   apcr_top dut_u (
      .MCLK_IN(clk), .RST_N_IN(rst_n), .INIT_RST_IN(init_rst),
      .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite),
      .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PSTRB_IN(pstrb),
      .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
      .FAST_OSC_ON_IN(osc), .BANDGAP_ENABLE_OUT(bg), .REGULATOR_ENABLE_OUT(ren),
      .REGULATOR_LEVEL_SELECT_OUT(lvl), .REGULATOR_OFF_DRIVE_SELECT_OUT(drv),
      .REF_OUT_BUFFER_ENABLE_OUT(buf_en), .REF_DIVIDER_ENABLE_OUT(div_en),
      .ANALOG_GROUND_LEVEL_SELECT_OUT(gnd), .CHARGE_PUMP_ENABLE_OUT(pump),
      .PUMP_OUTPUT_SELECT_OUT(psel_out), .REGULATOR_PULLDOWN_ENABLE_OUT(pd),
      .TEMP_SENSOR_ENABLE_OUT(temp), .REF_BUFFER_SOURCE_SELECT_OUT(src)
   );

   always #20 clk = ~clk;

   task automatic report_and_stop;
      $display("Comparisons %0d, mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One APB transfer; the request is held until pready is seen high
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s, input logic [31:0] exp_rd, input logic exp_err);
      int n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         n_fail++;
         $display("wrong value pready expected 1 seen %b", pready);
         report_and_stop();
      end
      chk("slave error", {31'h0, exp_err}, {31'h0, pslverr});
      if (!wr) begin
         chk("read data", exp_rd, prdata);
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Analog control levels, looked at once the write edge has settled
   task automatic outs(input logic [16:0] exp);
      @(negedge clk);
      chk("analog outputs", {15'h0, exp},
          {15'h0, bg, ren, lvl, drv, buf_en, div_en, gnd, pump, psel_out, pd, temp, src});
   endtask

   initial begin
      logic [1:0] exp_drv;
      logic [2:0] exp_gnd;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      outs(17'b1_0_000_00_0_0_000_0_0_0_0_0);
      xfer(1'b0, A_PC, 32'h0, 4'hf, 32'h80, 1'b0);
      xfer(1'b0, A_PR, 32'h0, 4'hf, 32'h00, 1'b0);
      xfer(1'b0, A_PS, 32'h0, 4'hf, 32'h00, 1'b0);
      xfer(1'b0, A_NW, 32'h0, 4'hf, 32'h00, 1'b0);
      xfer(1'b1, A_PC, 32'h7e, 4'hf, 32'h0, 1'b0);
      repeat (SETTLE_CYCLES) @(posedge clk);
      outs(17'b0_1_111_00_0_0_000_0_0_0_0_0);
      xfer(1'b0, A_PC, 32'h0, 4'hf, 32'h72, 1'b0);
      for (int c = 0; c < 4; c++) begin
         exp_drv = (c == 3) ? 2'h0 : 2'(c);
         xfer(1'b1, A_PC, {24'h0, 8'hd0 | 8'(c << 2)}, 4'hf, 32'h0, 1'b0);
         outs({1'b1, 1'b0, 3'b101, exp_drv, 10'h000});
         xfer(1'b0, A_PC, 32'h0, 4'hf, 32'hd0, 1'b0);
      end
      xfer(1'b1, A_PC, 32'h00, 4'hf, 32'h0, 1'b0);
      outs(17'h00000);
      @(posedge clk);
      osc <= 1'b1;
      repeat (2) @(posedge clk);
      outs(17'b1_0_000_00_0_0_000_0_0_0_0_0);
      xfer(1'b0, A_PC, 32'h0, 4'hf, 32'h00, 1'b0);
      osc <= 1'b0;
      xfer(1'b1, A_PR, 32'h88, 4'hf, 32'h0, 1'b0);
      outs(17'b0_0_000_00_1_1_000_0_0_0_0_0);
      xfer(1'b0, A_PR, 32'h0, 4'hf, 32'h88, 1'b0);
      for (int c = 0; c < 8; c++) begin
         exp_gnd = (c <= 4) ? 3'(c) : 3'h0;
         xfer(1'b1, A_PR, 32'(c), 4'hf, 32'h0, 1'b0);
         outs({7'h00, 2'b00, exp_gnd, 5'h00});
         xfer(1'b0, A_PR, 32'h0, 4'hf, 32'(c), 1'b0);
      end
      xfer(1'b1, A_PR, 32'hff, 4'hf, 32'h0, 1'b0);
      xfer(1'b0, A_PR, 32'h0, 4'hf, 32'h8f, 1'b0);
      xfer(1'b1, A_PS, 32'h40, 4'hf, 32'h0, 1'b0);
      outs(17'b0_0_000_00_1_1_000_0_0_0_0_0);
      xfer(1'b0, A_PS, 32'h0, 4'hf, 32'h40, 1'b0);
      xfer(1'b1, A_PC, 32'h80, 4'hf, 32'h0, 1'b0);
      xfer(1'b1, A_PS, 32'hff, 4'hf, 32'h0, 1'b0);
      outs(17'b1_0_000_00_1_1_000_1_1_1_1_0);
      xfer(1'b0, A_PS, 32'h0, 4'hf, 32'hc6, 1'b0);
      xfer(1'b1, A_NW, 32'hff, 4'hf, 32'h0, 1'b0);
      outs(17'b1_0_000_00_1_1_000_1_1_1_1_1);
      xfer(1'b0, A_NW, 32'h0, 4'hf, 32'h40, 1'b0);
      // Unmapped place and a write with its byte strobe off change nothing
      xfer(1'b1, A_BAD, 32'hff, 4'hf, 32'h0, 1'b1);
      xfer(1'b0, A_BAD, 32'h0, 4'hf, 32'h0, 1'b1);
      xfer(1'b1, A_NW, 32'h00, 4'h0, 32'h0, 1'b0);
      xfer(1'b0, A_NW, 32'h0, 4'hf, 32'h40, 1'b0);
      xfer(1'b1, A_PC, 32'h78, 4'hf, 32'h0, 1'b0);
      outs(17'b0_0_111_10_1_1_000_1_1_1_1_1);
      // Second reset kind: band-gap set, off drive cleared, the rest kept
      @(posedge clk);
      init_rst <= 1'b1;
      @(posedge clk);
      init_rst <= 1'b0;
      outs(17'b1_0_111_00_1_1_000_1_1_1_1_1);
      xfer(1'b0, A_PC, 32'h0, 4'hf, 32'hf0, 1'b0);
      xfer(1'b0, A_PS, 32'h0, 4'hf, 32'hc6, 1'b0);
      // Full reset in mid-run brings every register back
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      outs(17'b1_0_000_00_0_0_000_0_0_0_0_0);
      xfer(1'b0, A_PR, 32'h0, 4'hf, 32'h00, 1'b0);
      xfer(1'b0, A_NW, 32'h0, 4'hf, 32'h00, 1'b0);
      report_and_stop();
   end
endmodule
`default_nettype wire
